// ---- logic/mlpc_core.sv ----
// Contract
// - bank holds 32 lines by 16 channels, 48-bit
// - reset clears bank select and counters
// - store copies shift word, advances channel
// - channel past 15 wraps, line advances
// - line past last scan line wraps
// - swap displays the just-written bank
// - 16-bit value sets on-time; zero stays off
// - split select bit 14 picks mode
// - 8+8 mode spreads over 256 sub-periods
// - 7+9 mode spreads over 512 sub-periods
// - all lines show segment per sub-period
// - open detect only while output on
// - snapshot taken at 33rd grayscale edge
// - snapshot order red, green, blue
// - seven edges load snapshot at strobe fall
// - 48 serial clocks shift snapshot out
// - one edge is the store command
// - three edges swap banks, clear counters
// - serial output changes on serial rising edge and on readout load at strobe fall
`include "mlpc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module mlpc_core
   import mlpc_pkg::*;
#(
   parameter int CHANNELS = `MLPC_CHANNELS,
   parameter int MAX_LINES = `MLPC_MAX_LINES,
   parameter int BUF_DEPTH = 2
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic serial_clock,
   input wire logic load_strobe,
   input wire logic serial_input,
   input wire logic grayscale_clock,
   input wire logic [`MLPC_WORD_W-1:0] open_led_detect,
   input wire logic [`MLPC_FC2_W-1:0] function_config_two,
   output logic serial_output,
   output logic [`MLPC_WORD_W-1:0] sink_output,
   output logic [`MLPC_WORD_W-1:0] open_fault_snapshot,
   output logic display_bank,
   output logic store_overrun
);

   localparam int PIN_W = `MLPC_WORD_W + 4;
   localparam int ENTRY_W = 1 + `MLPC_LINE_W + `MLPC_CH_W + `MLPC_WORD_W;

   // pin synchronisers: meta is read only by sync
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic [2:0] edge_prev;
   logic sclk_s;
   logic lat_s;
   logic sin_s;
   logic grayscale_clock_s;
   logic [`MLPC_WORD_W-1:0] detect_s;
   logic sclk_rise;
   logic grayscale_clock_rise;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         edge_prev <= '0;
      end
      else
      begin
         pin_meta <= {open_led_detect, grayscale_clock, serial_input, load_strobe, serial_clock};
         pin_sync <= pin_meta;
         edge_prev <= {pin_sync[3], pin_sync[1], pin_sync[0]};
      end
   end

   assign sclk_s = pin_sync[0];
   assign lat_s = pin_sync[1];
   assign sin_s = pin_sync[2];
   assign grayscale_clock_s = pin_sync[3];
   assign detect_s = pin_sync[PIN_W-1:4];
   assign sclk_rise = sclk_s && !edge_prev[0];
   assign grayscale_clock_rise = grayscale_clock_s && !edge_prev[2];

   // configuration fields
   logic [`MLPC_LINE_W-1:0] max_line;
   mlpc_split_type split_mode;
   logic [8:0] seg_len;
   logic [8:0] sub_mask;

   assign max_line = function_config_two[`MLPC_FC2_LINES_LSB +: `MLPC_LINE_W];
   assign split_mode = mlpc_split_type'(function_config_two[`MLPC_FC2_SPLIT_BIT]);
   assign seg_len = (split_mode == MLPC_SPLIT_79) ? `MLPC_SEG_LEN_79 : `MLPC_SEG_LEN_88;
   assign sub_mask = (split_mode == MLPC_SPLIT_79) ? `MLPC_SUB_MASK_79 : `MLPC_SUB_MASK_88;

   // command framing: count serial edges while the strobe is high
   mlpc_link_type link_state;
   logic [3:0] edge_cnt;
   logic lat_fall;
   logic store_fire;
   logic swap_fire;
   logic readout_fire;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         link_state <= MLPC_SHIFT;
         edge_cnt <= '0;
      end
      else
      begin
         unique case (link_state)
            MLPC_SHIFT:
            begin
               edge_cnt <= '0;
               if (lat_s)
               begin
                  link_state <= MLPC_STROBE;
               end
            end
            MLPC_STROBE:
            begin
               if (!lat_s)
               begin
                  link_state <= MLPC_SHIFT;
               end
               else if (sclk_rise && edge_cnt != `MLPC_CMD_SAT)
               begin
                  edge_cnt <= edge_cnt + 4'h1;
               end
            end
         endcase
      end
   end

   assign lat_fall = (link_state == MLPC_STROBE) && !lat_s;
   assign store_fire = lat_fall && (edge_cnt == `MLPC_CMD_STORE);
   assign swap_fire = lat_fall && (edge_cnt == `MLPC_CMD_SWAP);
   assign readout_fire = lat_fall && (edge_cnt == `MLPC_CMD_READOUT);

   // common shift register; its top bit drives the serial output
   logic [`MLPC_WORD_W-1:0] shift_word;
   logic [`MLPC_WORD_W-1:0] next_shift;

   always_comb
   begin
      next_shift = shift_word;
      if (readout_fire)
      begin
         next_shift = open_fault_snapshot;
      end
      else if (sclk_rise)
      begin
         next_shift = {shift_word[`MLPC_WORD_W-2:0], sin_s};
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         shift_word <= '0;
         serial_output <= 1'b0;
      end
      else
      begin
         shift_word <= next_shift;
         serial_output <= next_shift[`MLPC_WORD_W-1];
      end
   end

   // write addressing
   logic bank_sel;
   logic [`MLPC_LINE_W-1:0] line_wr;
   logic [`MLPC_CH_W-1:0] chan_wr;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [ENTRY_W-1:0] buf_out_data;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bank_sel <= 1'b0;
         line_wr <= '0;
         chan_wr <= '0;
      end
      else if (swap_fire)
      begin
         bank_sel <= !bank_sel;
         line_wr <= '0;
         chan_wr <= '0;
      end
      else if (store_fire && buf_in_ready)
      begin
         chan_wr <= chan_wr + 1'b1;
         if (chan_wr == `MLPC_CH_W'(CHANNELS - 1))
         begin
            line_wr <= (line_wr == max_line) ? '0 : line_wr + 1'b1;
         end
      end
   end

   // a word that finds the buffer full is dropped and counters hold
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         store_overrun <= 1'b0;
      end
      else
      begin
         store_overrun <= store_fire && !buf_in_ready;
      end
   end

   logic disp_load;

   assign buf_out_ready = !disp_load;

   mlpc_buf2 #(
      .WIDTH(ENTRY_W),
      .DEPTH(BUF_DEPTH)
   ) u_store_buf (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(store_fire),
      .in_ready(buf_in_ready),
      .in_data({bank_sel, line_wr, chan_wr, shift_word}),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // two banks of line-by-channel words, flat index {bank, line, channel}
   logic [`MLPC_WORD_W-1:0] pixel_mem [2*MAX_LINES*CHANNELS];

   always_ff @(posedge clk_sys)
   begin
      if (buf_out_valid && buf_out_ready)
      begin
         pixel_mem[buf_out_data[ENTRY_W-1:`MLPC_WORD_W]] <= buf_out_data[`MLPC_WORD_W-1:0];
      end
   end

   // display sequencing: position in segment, line, sub-period
   logic [8:0] seg_pos;
   logic [`MLPC_LINE_W-1:0] line_disp;
   logic [8:0] sub_idx;

   assign display_bank = !bank_sel;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         seg_pos <= '0;
         line_disp <= '0;
         sub_idx <= '0;
         disp_load <= 1'b1;
      end
      else if (swap_fire)
      begin
         seg_pos <= '0;
         line_disp <= '0;
         sub_idx <= '0;
         disp_load <= 1'b1;
      end
      else if (grayscale_clock_rise && seg_pos >= seg_len - 9'h001)
      begin
         seg_pos <= '0;
         disp_load <= 1'b1;
         if (line_disp >= max_line)
         begin
            line_disp <= '0;
            sub_idx <= (sub_idx + 9'h001) & sub_mask;
         end
         else
         begin
            line_disp <= line_disp + 1'b1;
         end
      end
      else
      begin
         disp_load <= 1'b0;
         if (grayscale_clock_rise)
         begin
            seg_pos <= seg_pos + 9'h001;
         end
      end
   end

   // line words latched once per segment; write port yields that cycle
   logic [`MLPC_WORD_W-1:0] disp_word [CHANNELS];
   logic [8:0] sub_rev9;
   logic [7:0] sub_rev8;

   always_comb
   begin
      sub_rev9 = '0;
      sub_rev8 = '0;
      for (int b = 0; b < 9; b++)
      begin
         sub_rev9[b] = sub_idx[8-b];
      end
      for (int b = 0; b < 8; b++)
      begin
         sub_rev8[b] = sub_idx[7-b];
      end
   end

   genvar c;
   generate
      for (c = 0; c < CHANNELS; c++)
      begin : g_chan
         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
            begin
               disp_word[c] <= '0;
            end
            else if (disp_load)
            begin
               disp_word[c] <= pixel_mem[{display_bank, line_disp, `MLPC_CH_W'(c)}];
            end
         end
      end
   endgenerate

   // per output: base on-time plus one extra period in bit-reversed sub-periods
   genvar o;
   generate
      for (o = 0; o < `MLPC_WORD_W; o++)
      begin : g_out
         localparam int CH = o % CHANNELS;
         localparam int FIELD = (2 - (o / CHANNELS)) * `MLPC_GS_W;
         logic [`MLPC_GS_W-1:0] gs;
         logic [8:0] on_len;

         assign gs = disp_word[CH][FIELD +: `MLPC_GS_W];

         always_comb
         begin
            if (split_mode == MLPC_SPLIT_79)
            begin
               on_len = {2'b00, gs[15:9]} + {8'h00, (sub_rev9 < gs[8:0])};
            end
            else
            begin
               on_len = {1'b0, gs[15:8]} + {8'h00, (sub_rev8 < gs[7:0])};
            end
         end

         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
            begin
               sink_output[o] <= 1'b0;
               open_fault_snapshot[o] <= 1'b0;
            end
            else
            begin
               sink_output[o] <= (seg_pos < on_len);
               if (grayscale_clock_rise && seg_pos == `MLPC_CAPTURE_POS)
               begin
                  open_fault_snapshot[o] <= detect_s[o] && sink_output[o];
               end
            end
         end
      end
   endgenerate

endmodule // mlpc_core

`default_nettype wire

// ---- shared/mlpc_defs.svh ----
`ifndef MLPC_DEFS_SVH
`define MLPC_DEFS_SVH

// storage geometry
`define MLPC_WORD_W 48
`define MLPC_CHANNELS 16
`define MLPC_CH_W 4
`define MLPC_MAX_LINES 32
`define MLPC_LINE_W 5
`define MLPC_ADDR_W 10
`define MLPC_GS_W 16

// second function configuration word
`define MLPC_FC2_W 17
`define MLPC_FC2_LINES_LSB 0
`define MLPC_FC2_SPLIT_BIT 14

// command codes: serial clock rising edges counted while the strobe is high
`define MLPC_CMD_STORE 4'h1
`define MLPC_CMD_SWAP 4'h3
`define MLPC_CMD_READOUT 4'h7
`define MLPC_CMD_SAT 4'hF

// segment lengths in grayscale clocks, sub-period masks, and the capture position
`define MLPC_SEG_LEN_88 9'h101
`define MLPC_SEG_LEN_79 9'h081
`define MLPC_SUB_MASK_88 9'h0FF
`define MLPC_SUB_MASK_79 9'h1FF
`define MLPC_CAPTURE_POS 9'h020

`endif

// ---- shared/mlpc_pkg.sv ----
package mlpc_pkg;

   typedef enum logic [1:0] {
      MLPC_SHIFT = 2'b01,
      MLPC_STROBE = 2'b10
   } mlpc_link_type;

   typedef enum logic {
      MLPC_SPLIT_88 = 1'b0,
      MLPC_SPLIT_79 = 1'b1
   } mlpc_split_type;

endpackage

// ---- logic/mlpc_buf2.sv ----
`timescale 1ns/100ps
`default_nettype none

module mlpc_buf2 #(
   parameter int WIDTH = 58,
   parameter int DEPTH = 2
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0] fill;
   logic push;
   logic pop;

   assign in_ready = (fill != (PTR_W+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data = slot[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         slot[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop)
         begin
            fill <= fill + 1'b1;
         end
         else if (pop && !push)
         begin
            fill <= fill - 1'b1;
         end
      end
   end

endmodule // mlpc_buf2

`default_nettype wire

// ---- test/mlpc_core_checker.sv ----
`include "mlpc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module mlpc_core_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic serial_clock,
   input wire logic load_strobe,
   input wire logic grayscale_clock,
   input wire logic serial_output,
   input wire logic [`MLPC_WORD_W-1:0] sink_output,
   input wire logic [`MLPC_WORD_W-1:0] open_fault_snapshot,
   input wire logic display_bank,
   input wire logic store_overrun
);
   logic grayscale_clock_q;
   logic [3:0] gs_quiet;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // cycles since the grayscale pin last moved, saturating
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         grayscale_clock_q <= 1'b0;
         gs_quiet <= 4'hF;
      end
      else
      begin
         grayscale_clock_q <= grayscale_clock;
         if (grayscale_clock != grayscale_clock_q)
            gs_quiet <= 4'h0;
         else if (gs_quiet != 4'hF)
            gs_quiet <= gs_quiet + 4'h1;
      end
   end

   a_reset_state: assert property ($fell(rst) |-> display_bank && sink_output == '0)
      else $error("outputs not cleared by reset");
   a_snap_on_grayscale_clock: assert property ($changed(open_fault_snapshot) |-> gs_quiet < 4'h8)
      else $error("snapshot moved without a grayscale edge");
   a_snap_only_on: assert property ($changed(open_fault_snapshot) |->
      (open_fault_snapshot & ~$past(sink_output)) == '0)
      else $error("fault bit set for an output that was off");
   a_overrun_pulse: assert property (store_overrun |->
      !load_strobe && $past(load_strobe, 7) ##1 !store_overrun)
      else $error("overrun pulse not tied to a strobe fall");
   a_bank_on_fall: assert property ($changed(display_bank) |->
      $past(load_strobe, 7) && !$past(load_strobe, 2))
      else $error("bank changed away from a strobe fall");
   a_bank_steady: assert property (load_strobe [*8] |-> $stable(display_bank))
      else $error("bank changed while strobe high");
   // a rise seen 3 or 4 cycles late, the pin high 6 cycles
   a_serial_output_on_edge: assert property ($changed(serial_output) |->
      ($past(serial_clock, 2) && !$past(serial_clock, 8)) ||
      ($past(load_strobe, 8) && !$past(load_strobe, 2)))
      else $error("serial output moved without a shift edge");
   a_sink_on_grayscale_clock: assert property ($changed(sink_output) |-> gs_quiet < 4'h8 || $past(load_strobe, 9))
      else $error("outputs moved without grayscale clock or swap");
endmodule // mlpc_core_checker

bind mlpc_core mlpc_core_checker chk (.clk_sys, .rst, .serial_clock, .load_strobe, .grayscale_clock,
   .serial_output, .sink_output, .open_fault_snapshot, .display_bank, .store_overrun);

`default_nettype wire

// ---- test/mlpc_ctrl_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module mlpc_ctrl_model (
   input wire logic clk_sys,
   output logic serial_clock,
   output logic load_strobe,
   output logic serial_input,
   output logic grayscale_clock
);
   initial
   begin
      serial_clock = 1'b0;
      load_strobe = 1'b0;
      serial_input = 1'b0;
      grayscale_clock = 1'b0;
   end

   // whole word MSB first, strobe up for the last n rises
   task automatic cmd(input logic [47:0] w, input int n);
      @(negedge clk_sys);
      #1;
      for (int i = 47; i >= 0; i--)
      begin
         serial_input = w[i];
         load_strobe = i < n;
         #62.5 serial_clock = 1'b1;
         #62.5 serial_clock = 1'b0;
      end
      // released line shows the inverse; clock stands low
      serial_input = ~w[0];
      load_strobe = 1'b0;
   endtask

   // gap first so the loaded word is out before the first rise
   task automatic rd();
      @(negedge clk_sys);
      #126;
      repeat (48)
      begin
         serial_clock = 1'b1;
         #62.5 serial_clock = 1'b0;
         #62.5;
      end
   endtask

   // lines only switch between segments
   task automatic gs(input int n);
      @(negedge clk_sys);
      #1;
      repeat (n)
      begin
         grayscale_clock = 1'b1;
         #40 grayscale_clock = 1'b0;
         #40;
      end
   endtask
endmodule // mlpc_ctrl_model

`default_nettype wire

// ---- test/tb_mlpc_core.sv ----
`include "mlpc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_mlpc_core;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic serial_clock, load_strobe, serial_input, grayscale_clock;
   logic serial_output, display_bank, store_overrun, bank_exp;
   logic rd_on = 1'b0;
   logic [47:0] det = '0;
   logic [47:0] sink_output, snap, acc;
   logic [47:0] mem [32];
   logic [15:0] edge_gs [3] = '{16'h0000, 16'h2000, 16'h2001};
   logic [16:0] cfg = 17'h00001;
   logic [31:0] seed = 32'h7FF1469D;
   logic [47:0] q_word [$];
   logic q_bank [$];
   int error_cnt = 0;
   int samples_checked = 0;
   int nb = 0;
   // sticky: stores are spaced far apart, so no word may ever be dropped
   logic ovr_seen = 1'b0;

   mlpc_ctrl_model partner (.clk_sys, .serial_clock, .load_strobe, .serial_input, .grayscale_clock);
   mlpc_core dut (.clk_sys, .rst, .serial_clock, .load_strobe, .serial_input, .grayscale_clock,
      .open_led_detect(det), .function_config_two(cfg), .serial_output, .sink_output,
      .open_fault_snapshot(snap), .display_bank, .store_overrun);

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys)
      if (!rst && store_overrun !== 1'b0)
         ovr_seen = 1'b1;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // on at position 32 of sub-period 0
   function automatic logic on(input logic [15:0] g);
      if (cfg[`MLPC_FC2_SPLIT_BIT])
         return int'(g[15:9]) + int'(g[8:0] != 0) > 32;
      return int'(g[15:8]) + int'(g[7:0] != 0) > 32;
   endfunction

   function automatic logic [47:0] exp_sink(input int ln);
      logic [47:0] r;
      for (int c = 0; c < 16; c++)
      begin
         r[32 + c] = on(mem[ln * 16 + c][15:0]);
         r[16 + c] = on(mem[ln * 16 + c][31:16]);
         r[c] = on(mem[ln * 16 + c][47:32]);
      end
      return r;
   endfunction

   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wrap_up();
      $display("samples %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge serial_clock)
      if (rd_on)
      begin
         acc = {acc[46:0], serial_output};
         nb++;
         if (nb == 48)
         begin
            nb = 0;
            chk("readout", q_word.pop_front(), acc);
         end
      end

   // an unexpected change compares against its own inverse
   always @(display_bank)
      if (!rst)
      begin
         bank_exp = q_bank.size() ? q_bank.pop_front() : ~display_bank;
         chk("bank", {47'h0, bank_exp}, {47'h0, display_bank});
      end

   task automatic frame(input logic split, input logic bank);
      logic [31:0] a, b;
      @(negedge clk_sys);
      cfg = {2'b00, split, 14'h0001};
      for (int i = 0; i < 32; i++)
      begin
         a = rnd();
         b = rnd();
         mem[i] = {2'b00, a[13:0], 2'b00, a[29:16], 2'b00, b[13:0]};
         if (i < 3)
            mem[i][15:0] = edge_gs[i];
         partner.cmd(mem[i], 1);
      end
      q_bank.push_back(bank);
      partner.cmd('0, 3);
      #2500;
      for (int ln = 0; ln < 2; ln++)
      begin
         a = rnd();
         b = rnd();
         @(negedge clk_sys);
         det = {a, b[15:0]};
         partner.gs(32);
         chk("sink", exp_sink(ln), sink_output);
         partner.gs(1);
         chk("snapshot", det & exp_sink(ln), snap);
         partner.gs(split ? 96 : 224);
      end
      q_word.push_back(det & exp_sink(1));
      partner.cmd('0, 7);
      rd_on = 1'b1;
      partner.rd();
      rd_on = 1'b0;
   endtask

   initial
   begin
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      chk("reset bank", 48'h1, {47'h0, display_bank});
      chk("reset outs", '0, sink_output | snap | 48'(serial_output));
      $display("reset test done");
      frame(1'b0, 1'b0);
      $display("8+8 frame done");
      frame(1'b1, 1'b1);
      $display("7+9 frame done");
      chk("pending", '0, 48'(q_word.size() + q_bank.size()));
      chk("overrun", '0, {47'h0, ovr_seen});
      wrap_up();
   end

   initial
   begin
      #900000;
      error_cnt++;
      wrap_up();
   end
endmodule // tb_mlpc_core

`default_nettype wire
